/* File: hdl/ssps_clkgen.v */
// Half-period tick generator for the master serial clock.
// Assumes the timer two output is a one-cycle pulse synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
`include "ssps_defines.vh"

module ssps_clkgen (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Control
  input wire run,
  input wire [3:0] mode,
  input wire timer_two_output,
  // Tick out
  output wire tick
);

  // ==========================================================
  // Divider
  reg [6:0] cnt_q;
  reg [6:0] lim;
  wire cnt_hit;

  always @*
  begin
    case (mode)
      `SSPS_MODE_DIV4: lim = (`SSPS_DIV_FAST >> 1) - 7'h01;
      `SSPS_MODE_DIV16: lim = (`SSPS_DIV_MED >> 1) - 7'h01;
      default: lim = (`SSPS_DIV_SLOW >> 1) - 7'h01;
    endcase
  end

  assign cnt_hit = (cnt_q == lim);

  // Restarting while idle makes the first edge a full half-period after the start.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= 7'h00;
    else if (!run || cnt_hit)
      cnt_q <= 7'h00;
    else
      cnt_q <= cnt_q + 7'h01;
  end

  // Each timer pulse is one half-period, giving the timer rate divided by two.
  assign tick = run & ((mode == `SSPS_MODE_TIMER_TWO_OUTPUT) ? timer_two_output : cnt_hit); // RQ9 RQ8

endmodule // ssps_clkgen
`default_nettype wire

/* File: hdl/ssps_defines.vh */
// Constants for the synchronous serial port in SPI operation.
// Assumes inclusion by bare name from the files under hdl/.
`ifndef SSPS_DEFINES_VH
`define SSPS_DEFINES_VH

// ==========================================================
// Register byte offsets
`define SSPS_OFF_CTL 8'h14
`define SSPS_OFF_STAT 8'h18
`define SSPS_OFF_BUF 8'h1c
`define SSPS_OFF_IRQ 8'h20

// ==========================================================
// Field positions
`define SSPS_CTL_WRITE_COLLISION_FLAG 7
`define SSPS_CTL_OVF 6
`define SSPS_CTL_EN 5
`define SSPS_CTL_CKP 4
`define SSPS_STAT_SMP 7
`define SSPS_STAT_CKE 6
`define SSPS_STAT_BF 0
`define SSPS_IRQ_PORT 3

// ==========================================================
// Reset values
`define SSPS_CTL_RST 8'h00
`define SSPS_STAT_RST 8'h00
`define SSPS_IRQ_RST 1'b0

// ==========================================================
// Mode codes
`define SSPS_MODE_DIV4 4'h0
`define SSPS_MODE_DIV16 4'h1
`define SSPS_MODE_DIV64 4'h2
`define SSPS_MODE_TIMER_TWO_OUTPUT 4'h3
`define SSPS_MODE_SLV_SS 4'h4
`define SSPS_MODE_SLV_NOSS 4'h5

// ==========================================================
// Timing counts: divider ratios, serial clock phases and last bit index
`define SSPS_DIV_FAST 7'h04
`define SSPS_DIV_MED 7'h10
`define SSPS_DIV_SLOW 7'h40
`define SSPS_PH_LAST 5'h0f
`define SSPS_PH_EXTRA 5'h10
`define SSPS_LAST_BIT 4'h7

`endif

/* File: hdl/ssps_top.v */
// Synchronous serial port in SPI operation with an AHB-Lite register slave.
// Assumes serial pins are synchronous to hclk and a single-word AHB-Lite master.
//
// Summary of operation
// RQ1: buffer write while shifting sets collision flag
// RQ2: colliding buffer write is discarded entirely
// RQ3: slave byte into full buffer sets overflow
// RQ4: master operation never sets overflow flag
// RQ5: software reads buffer after every transfer
// RQ6: enable bit hands pins to port
// RQ7: polarity bit sets serial clock idle level
// RQ8: modes 0-2 master at divide 4/16/64
// RQ9: mode 3 master at half timer rate
// RQ10: modes 4/5 slave, with/without slave select
// RQ11: software avoids reserved mode codes
// RQ12: master drives clock, slave receives it
// RQ13: eight bits exchanged simultaneously per transfer
// RQ14: shifting is most significant bit first
// RQ15: completed byte loads buffer, sets flags
// RQ16: next reception may start before read
// RQ17: buffer read clears buffer full flag
// RQ18: shift register reached only through buffer
// RQ19: software reads before writing, advisory only
// RQ20: edge bit selects transmit clock edge
// RQ21: sample phase bit: end or middle
// RQ22: master buffer write starts transfer immediately
// RQ23: select high floats data out at once
// RQ24: master gives eight clocks, then idles
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ssps_defines.vh"

module ssps_top (
  // AHB-Lite slave
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Serial clock pin
  input wire sck_i,
  output wire sck_o,
  output wire sck_oe,
  // Serial data pins
  input wire sdi_i,
  output wire sdo_o,
  output wire sdo_oe,
  // Slave select and timer
  input wire ss_n_i,
  input wire timer_two_output,
  // Pin ownership
  output wire serial_pins_owned,
  output wire ss_pin_owned
);

  // ==========================================================
  // State
  reg write_collision_flag_q;
  reg ovf_q;
  reg en_q;
  reg ckp_q;
  reg [3:0] mode_q;
  reg smp_q;
  reg cke_q;
  reg bf_q;
  reg irq_q;
  reg [7:0] rxbuf_q;
  reg [7:0] tx_q;
  reg [7:0] rx_q;
  reg out_q;
  reg sck_q;
  reg run_q;
  reg [4:0] ph_q;
  reg [3:0] cnt_q;
  reg sck_prev_q;
  reg wr_pend_q;
  reg [7:0] adr_q;
  reg [31:0] hrdata_q;

  // Status reset pattern; its stored bits are picked out one by one at reset.
  localparam [7:0] stat_rst = `SSPS_STAT_RST;

  // ==========================================================
  // Bus decode
  wire acc = hsel & htrans[1] & hready;
  wire rd_acc = acc & ~hwrite;
  wire wr_acc = acc & hwrite;
  wire [7:0] a_off = haddr[7:0];
  wire wr_ctl = wr_pend_q & (adr_q == `SSPS_OFF_CTL);
  wire wr_stat = wr_pend_q & (adr_q == `SSPS_OFF_STAT);
  wire wr_buf = wr_pend_q & (adr_q == `SSPS_OFF_BUF);
  wire wr_irq = wr_pend_q & (adr_q == `SSPS_OFF_IRQ);
  wire rd_buf = rd_acc & (a_off == `SSPS_OFF_BUF);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // ==========================================================
  // Mode decode
  wire is_master = (mode_q[3:2] == 2'b00); // RQ8 RQ9
  wire is_slave = (mode_q == `SSPS_MODE_SLV_SS) | (mode_q == `SSPS_MODE_SLV_NOSS); // RQ10
  wire ss_ctl = (mode_q == `SSPS_MODE_SLV_SS);
  wire m_act = en_q & is_master;
  wire s_sel = en_q & is_slave & (~ss_ctl | ~ss_n_i);
  // A raised select in the select-controlled mode abandons the partial byte.
  wire s_abort = en_q & ss_ctl & ss_n_i;

  // ==========================================================
  // Master tick source
  wire tick;

  ssps_clkgen u_clkgen (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run_q),
    .mode(mode_q),
    .timer_two_output(timer_two_output),
    .tick(tick)
  );

  // ==========================================================
  // Edge events
  wire m_tick = run_q & tick;
  wire m_tx = m_tick & (ph_q[0] == ~cke_q) & (ph_q != `SSPS_PH_EXTRA); // RQ20
  wire m_smp = m_tick & (smp_q ? ((ph_q[0] == ~cke_q) & (ph_q != 5'h00)) : (ph_q[0] == cke_q)); // RQ21
  wire [4:0] m_last = (cke_q & smp_q) ? `SSPS_PH_EXTRA : `SSPS_PH_LAST;
  wire m_done = m_tick & (ph_q == m_last); // RQ24

  wire s_edge = s_sel & (sck_i ^ sck_prev_q);
  wire s_lead = s_edge & (sck_prev_q == ckp_q);
  wire s_trail = s_edge & (sck_prev_q != ckp_q);
  wire s_tx = cke_q ? s_lead : s_trail; // RQ20
  wire s_smp = cke_q ? s_trail : s_lead;
  wire s_done = s_smp & (cnt_q == `SSPS_LAST_BIT); // RQ13

  wire tx_ev = m_act ? m_tx : s_tx;
  wire smp_ev = m_act ? m_smp : s_smp;
  wire [7:0] rx_nxt = {rx_q[6:0], sdi_i}; // RQ14
  wire [7:0] rx_fin = smp_ev ? rx_nxt : rx_q;

  // ==========================================================
  // Buffer write acceptance
  wire busy = run_q | (s_sel & (cnt_q != 4'h0));
  wire start = wr_buf & en_q & (is_master | is_slave) & ~busy; // RQ22 RQ2
  wire collide = wr_buf & en_q & busy; // RQ1

  // A slave byte completing into a full buffer is dropped; a read in the same cycle frees it.
  wire bf_busy = bf_q & ~rd_buf;
  wire m_load = m_act & m_done;
  wire s_load = ~m_act & s_done & ~bf_busy; // RQ16
  wire s_over = ~m_act & s_done & bf_busy; // RQ3 RQ4
  wire load = m_load | s_load;
  wire done = m_load | s_done;

  // ==========================================================
  // Control, status and flag registers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {write_collision_flag_q, ovf_q, en_q, ckp_q, mode_q} <= `SSPS_CTL_RST;
      smp_q <= stat_rst[`SSPS_STAT_SMP];
      cke_q <= stat_rst[`SSPS_STAT_CKE];
      bf_q <= stat_rst[`SSPS_STAT_BF];
      irq_q <= `SSPS_IRQ_RST;
    end
    else
    begin
      if (wr_ctl)
      begin
        en_q <= hwdata[`SSPS_CTL_EN]; // RQ6
        ckp_q <= hwdata[`SSPS_CTL_CKP]; // RQ7
        mode_q <= hwdata[3:0];
      end
      // Hardware setting wins over a software clear in the same cycle.
      write_collision_flag_q <= collide | (wr_ctl ? hwdata[`SSPS_CTL_WRITE_COLLISION_FLAG] : write_collision_flag_q); // RQ1
      ovf_q <= s_over | (wr_ctl ? hwdata[`SSPS_CTL_OVF] : ovf_q); // RQ3
      if (wr_stat)
      begin
        smp_q <= hwdata[`SSPS_STAT_SMP];
        cke_q <= hwdata[`SSPS_STAT_CKE];
      end
      bf_q <= load | (bf_q & ~rd_buf); // RQ15 RQ17
      irq_q <= done | (wr_irq ? hwdata[`SSPS_IRQ_PORT] : irq_q); // RQ15
    end
  end

  // ==========================================================
  // Shift engine
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rxbuf_q <= 8'h00;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      out_q <= 1'b0;
      sck_q <= 1'b0;
      run_q <= 1'b0;
      ph_q <= 5'h00;
      cnt_q <= 4'h0;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      sck_prev_q <= sck_i;
      if (load)
        rxbuf_q <= rx_fin; // RQ15
      if (!en_q || s_abort)
      begin
        run_q <= 1'b0;
        cnt_q <= 4'h0;
        ph_q <= 5'h00;
        sck_q <= ckp_q;
      end
      else if (start)
      begin
        // The first bit must be on the line before the first edge when data changes on trailing edges.
        if (!cke_q)
        begin
          out_q <= hwdata[7]; // RQ14
          tx_q <= {hwdata[6:0], 1'b0};
        end
        else
          tx_q <= hwdata[7:0]; // RQ18
        cnt_q <= 4'h0;
        ph_q <= 5'h00;
        run_q <= is_master; // RQ22
        sck_q <= ckp_q;
      end
      else
      begin
        if (tx_ev)
        begin
          out_q <= tx_q[7]; // RQ13 RQ14
          tx_q <= {tx_q[6:0], 1'b0};
        end
        if (smp_ev)
        begin
          rx_q <= rx_nxt; // RQ13
          cnt_q <= done ? 4'h0 : cnt_q + 4'h1;
        end
        if (m_done)
        begin
          run_q <= 1'b0; // RQ24
          ph_q <= 5'h00;
        end
        else if (m_tick)
          ph_q <= ph_q + 5'h01;
        if (!run_q)
          sck_q <= ckp_q; // RQ7
        else if (m_tick && ph_q != `SSPS_PH_EXTRA)
          sck_q <= ~sck_q; // RQ24
      end
    end
  end

  // ==========================================================
  // Register bus slave
  reg [31:0] rd_mux;

  always @*
  begin
    case (a_off)
      `SSPS_OFF_CTL: rd_mux = {24'h000000, write_collision_flag_q, ovf_q, en_q, ckp_q, mode_q};
      `SSPS_OFF_STAT: rd_mux = {24'h000000, smp_q, cke_q, 5'h00, bf_q};
      `SSPS_OFF_BUF: rd_mux = {24'h000000, rxbuf_q}; // RQ18
      `SSPS_OFF_IRQ: rd_mux = {28'h0000000, irq_q, 3'h0};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      adr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
    end
    else
    begin
      wr_pend_q <= wr_acc;
      if (acc)
        adr_q <= a_off;
      if (rd_acc)
        hrdata_q <= rd_mux;
    end
  end

  // ==========================================================
  // Pin control
  assign sck_o = sck_q;
  assign sck_oe = m_act; // RQ12
  assign sdo_o = out_q;
  assign sdo_oe = m_act | s_sel; // RQ23 RQ6
  assign serial_pins_owned = en_q; // RQ6
  assign ss_pin_owned = en_q & ss_ctl; // RQ10

endmodule // ssps_top
`default_nettype wire

/* File: tb/ssps_partner.sv */
// Peripheral model on the far side of the serial pins.
// Assumes sck is the resolved clock line and cpol its idle level.
`timescale 1ns/1ps
`default_nettype none
module ssps_partner (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Serial line
  input wire logic sck,
  input wire logic cpol,
  input wire logic sdo_o,
  output logic sdi,
  // Model data
  input wire logic [7:0] reply,
  output logic [7:0] rx_byte
);
  // ==========================================================
  // Shifter
  logic prev_q, frame_q;
  logic [7:0] tx_q;
  logic [2:0] cnt_q;
  assign sdi = tx_q[7];
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      {prev_q, frame_q, tx_q, cnt_q, rx_byte} <= '0;
    else
    begin
      prev_q <= sck;
      // A polarity change alone never counts as a trailing edge.
      if (sck != cpol && prev_q == cpol)
      begin
        frame_q <= 1'b1;
        rx_byte <= {rx_byte[6:0], sdo_o};
      end
      else if (sck == cpol && frame_q)
      begin
        frame_q <= 1'b0;
        tx_q <= {tx_q[6:0], ~tx_q[7]};
        cnt_q <= cnt_q + 3'h1;
      end
      else if (cnt_q == 3'h0 && !frame_q)
        tx_q <= reply;
    end
endmodule // ssps_partner
`default_nettype wire

/* File: tb/ssps_properties.sv */
// Bus and pin relations at the top ports of the serial port.
// Assumes a bind into ssps_top, which has a single hclk domain.
`timescale 1ns/1ps
`default_nettype none
module ssps_properties (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Pins
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic sdo_oe,
  input wire logic ss_n_i,
  input wire logic serial_pins_owned,
  input wire logic ss_pin_owned
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
  read_hold_a: assert property ($changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite))
    else $error("read data moved without a read");
  sck_owned_a: assert property (sck_oe |-> serial_pins_owned && !ss_pin_owned)
    else $error("clock driven outside master mode");
  master_data_a: assert property (sck_oe |-> sdo_oe) else $error("master not driving data");
  disabled_float_a: assert property (!serial_pins_owned |-> !sck_oe && !sdo_oe && !ss_pin_owned)
    else $error("pins driven while disabled");
  select_float_a: assert property (ss_pin_owned && ss_n_i |-> !sdo_oe) else $error("data out not floated");
  select_drive_a: assert property (ss_pin_owned && !ss_n_i |-> sdo_oe) else $error("selected slave silent");
  half_period_a: assert property (sck_oe && $changed(sck_o) |=> $stable(sck_o))
    else $error("clock half period too short");
  cover property (sck_oe && $changed(sck_o));
  cover property (ss_pin_owned && !ss_n_i);
  cover property (!sck_oe && sdo_oe);
endmodule // ssps_properties
bind ssps_top ssps_properties u_ssps_properties (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .hresp(hresp), .sck_o(sck_o), .sck_oe(sck_oe),
  .sdo_oe(sdo_oe), .ss_n_i(ss_n_i), .serial_pins_owned(serial_pins_owned), .ss_pin_owned(ss_pin_owned));
`default_nettype wire

/* File: tb/test_sync_serial_port_spi.sv */
// Bench for the serial port: AHB-Lite register tasks against a peripheral model.
// Assumes the defines header, ssps_top, ssps_partner and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "ssps_defines.vh"
module test_sync_serial_port_spi;
  logic hclk, hresetn, hsel, hwrite, sck_i, ss_n_i, timer_two_output, cpol, sck_prev;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, rd;
  logic [7:0] reply;
  wire [31:0] hrdata;
  wire [7:0] rx_byte;
  wire hready, hresp, sck_o, sck_oe, sdi_i, sdo_o, sdo_oe, serial_pins_owned, ss_pin_owned;
  wire sck_w = sck_oe ? sck_o : sck_i;
  int n_fail, check_count, toggles, gap, cnt, tcnt, i, t0;
  int half [4] = '{`SSPS_DIV_FAST / 2, `SSPS_DIV_MED / 2, `SSPS_DIV_SLOW / 2, 5};
  ssps_top u_ssps_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi_i), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe), .ss_n_i(ss_n_i), .timer_two_output(timer_two_output),
    .serial_pins_owned(serial_pins_owned), .ss_pin_owned(ss_pin_owned));
  ssps_partner u_ssps_partner (.hclk(hclk), .hresetn(hresetn), .sck(sck_w), .cpol(cpol), .sdo_o(sdo_o),
    .sdi(sdi_i), .reply(reply), .rx_byte(rx_byte));
  // ==========================================================
  // Reporting and bus tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic lim(input bit bad, input string nm);
    if (bad)
    begin
      ck(nm, 1, 0);
      end_of_test();
    end
  endtask
  task automatic wt();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    lim(n >= 64, "hready_wait");
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wt();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wt();
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
    bus(1'b0, a, 8'h00);
    ck(nm, {24'h0, exp}, rd);
  endtask
  task automatic wait_bf();
    int n;
    n = 0;
    do
    begin
      bus(1'b0, `SSPS_OFF_STAT, 8'h00);
      n++;
    end
    while (rd[0] !== 1'b1 && n < 300);
    lim(n >= 300, "bf_wait");
  endtask
  // A slow external master: level changes well apart, idle low.
  task automatic sbyte();
    repeat (8)
    begin
      repeat (4) @(posedge hclk);
      sck_i <= 1'b1;
      repeat (4) @(posedge hclk);
      sck_i <= 1'b0;
    end
    repeat (4) @(posedge hclk);
  endtask
  // ==========================================================
  // Clock, timer pulses and clock-line monitor
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
    timer_two_output <= (tcnt == 4);
    sck_prev <= sck_o;
    if (sck_oe && sck_o !== sck_prev)
    begin
      gap <= cnt;
      cnt <= 1;
      toggles <= toggles + 1;
    end
    else
      cnt <= cnt + 1;
  end
  // ==========================================================
  // Sequence
  initial
  begin
    {hresetn, hsel, hwrite, sck_i, cpol} = '0;
    ss_n_i = 1'b1;
    htrans = 2'b00;
    haddr = '0;
    hwdata = '0;
    reply = 8'h00;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`SSPS_OFF_CTL, `SSPS_CTL_RST, "ctl_rst");
    rdc(`SSPS_OFF_STAT, `SSPS_STAT_RST, "stat_rst");
    rdc(`SSPS_OFF_IRQ, 8'h00, "irq_rst");
    rdc(8'h30, 8'h00, "unmapped");
    for (i = 0; i < 4; i++)
    begin
      cpol = i[0];
      bus(1'b1, `SSPS_OFF_CTL, {3'b001, cpol, i[3:0]});
      bus(1'b1, `SSPS_OFF_STAT, {i[1], 7'h00});
      // Let a clock level change from the polarity write reach the monitor first.
      repeat (4) @(posedge hclk);
      reply = 8'h3c ^ i[7:0];
      t0 = toggles;
      bus(1'b1, `SSPS_OFF_BUF, 8'ha5 + i[7:0]);
      if (i == 0)
        bus(1'b1, `SSPS_OFF_BUF, 8'h0f);
      wait_bf();
      ck("toggles", 16, toggles - t0);
      ck("half", half[i], gap);
      ck("sck_idle", {31'h0, cpol}, {31'h0, sck_o});
      ck("far_rx", {24'h0, 8'ha5 + i[7:0]}, {24'h0, rx_byte});
      rdc(`SSPS_OFF_BUF, reply, "buf");
      rdc(`SSPS_OFF_STAT, {i[1], 7'h00}, "bf_clr");
      rdc(`SSPS_OFF_IRQ, 8'h01 << `SSPS_IRQ_PORT, "irq");
      rdc(`SSPS_OFF_CTL, {i == 0, 2'b01, cpol, i[3:0]}, "ctl");
      bus(1'b1, `SSPS_OFF_IRQ, 8'h00);
    end
    cpol = 1'b0;
    bus(1'b1, `SSPS_OFF_CTL, 8'h00);
    bus(1'b1, `SSPS_OFF_STAT, 8'h00);
    bus(1'b1, `SSPS_OFF_CTL, {4'h2, `SSPS_MODE_SLV_NOSS});
    reply = 8'h5a;
    bus(1'b1, `SSPS_OFF_BUF, 8'hc3);
    sbyte();
    ck("slave_rx", 32'hc3, {24'h0, rx_byte});
    rdc(`SSPS_OFF_STAT, 8'h01, "slave_bf");
    reply = 8'h66;
    sbyte();
    rdc(`SSPS_OFF_CTL, 8'h65, "overflow");
    rdc(`SSPS_OFF_BUF, 8'h5a, "kept");
    bus(1'b1, `SSPS_OFF_CTL, {4'h2, `SSPS_MODE_SLV_SS});
    // The mode lands at the edge that ends the write, so look one edge later.
    @(posedge hclk);
    ck("ss_high", 32'h2, {30'h0, ss_pin_owned, sdo_oe});
    ss_n_i <= 1'b0;
    repeat (2) @(posedge hclk);
    ck("ss_low", 32'h3, {30'h0, ss_pin_owned, sdo_oe});
    end_of_test();
  end
endmodule // test_sync_serial_port_spi
`default_nettype wire
